// >>> rtl/pms_ctl.sv
// Controller end: builds management frames from a small register port.
// Assumes one device end on the link and software that polls or takes the interrupt.
`timescale 1ns/10ps
module pms_ctl #(
  parameter int HALF = pms_pkg::MDC_HALF_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  output logic o_irq,
  pms_if.ctl link
);
  pms_pkg::pms_ctl_state_t state;
  logic [63:0] frame;     // Bits still to send, msb first
  logic [5:0] idx;        // Position of the bit on the line
  logic [7:0] div;        // Half-period divider
  logic op_rd;            // Frame in flight is a read
  logic [15:0] wdata;     // Data for the next write frame
  logic [15:0] rdata;     // Data of the last read frame
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic [1:0] ev;         // Completion events this cycle
  logic mdio_s;
  logic start;
  logic half_done;

  // Divider must fit its counter; below three the device answer misses the next rise
  if (HALF < 3 || HALF > 255) begin : g_bad_half
    $error("pms_ctl HALF out of range");
  end

  // Returning data crosses from the device side
  pms_sync #(.W(1)) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_d(link.mdio),
    .o_q(mdio_s),
    .o_rise()
  );

  // A command while busy is dropped
  assign start = i_wr && (i_addr == pms_pkg::CTL_CMD) && (state == pms_pkg::C_IDLE);
  assign half_done = (div == 8'(HALF - 1));

  // this end makes the link clock by division
  // data changes on falls, read data sampled on rises
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= pms_pkg::C_IDLE;
      frame <= 64'h0000000000000000;
      idx <= 6'h00;
      div <= 8'h00;
      op_rd <= 1'b0;
      rdata <= 16'h0000;
      ev <= 2'h0;
      link.mdc <= 1'b0;
      link.ctl_mdio_o <= 1'b1;
      link.ctl_mdio_oe_n <= 1'b1;
    end else begin
      ev <= 2'h0;
      case (state)
        pms_pkg::C_IDLE: begin
          if (start) begin
            // write turnaround is 10; read bits are overwritten by release
            frame <= {32'hFFFFFFFF, pms_pkg::START_PAT,
                      i_wdata[pms_pkg::CMD_READ_BIT] ? pms_pkg::OP_RD : pms_pkg::OP_WR,
                      i_wdata[9:0], pms_pkg::TA_WR, wdata};
            op_rd <= i_wdata[pms_pkg::CMD_READ_BIT];
            idx <= 6'h00;
            div <= 8'h00;
            link.ctl_mdio_o <= 1'b1;
            link.ctl_mdio_oe_n <= 1'b0;
            state <= pms_pkg::C_RUN;
          end
        end
        pms_pkg::C_RUN: begin
          div <= div + 8'h01;
          if (half_done) begin
            div <= 8'h00;
            link.mdc <= ~link.mdc;
            if (!link.mdc) begin
              // read data taken on the rise
              if (op_rd && idx >= 6'(pms_pkg::DATA_FIRST_BIT)) begin
                rdata <= {rdata[14:0], mdio_s};
              end
            end else if (idx == 6'(pms_pkg::FRAME_BITS - 1)) begin
              link.ctl_mdio_oe_n <= 1'b1;
              link.ctl_mdio_o <= 1'b1;
              ev <= op_rd ? 2'h2 : 2'h1;
              state <= pms_pkg::C_IDLE;
            end else begin
              idx <= idx + 6'h01;
              frame <= {frame[62:0], 1'b0};
              link.ctl_mdio_o <= frame[62];
              // release from the first turnaround bit of a read
              link.ctl_mdio_oe_n <= op_rd && (idx >= 6'(pms_pkg::TA_FIRST_BIT - 1));
            end
          end
        end
        default: begin
          state <= pms_pkg::C_IDLE;
        end
      endcase
    end
  end

  // software reaches the device only through these frames
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wdata <= 16'h0000;
      irq_mask <= 2'h0;
    end else if (i_wr) begin
      if (i_addr == pms_pkg::CTL_WDATA) begin
        wdata <= i_wdata;
      end
      if (i_addr == pms_pkg::CTL_IRQ_MASK) begin
        irq_mask <= i_wdata[1:0];
      end
    end
  end

  // Sticky completion flags; read clears, a new event wins
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_stat <= 2'h0;
    end else begin
      irq_stat <= ((i_rd && i_addr == pms_pkg::CTL_IRQ_STAT) ? 2'h0 : irq_stat) | ev;
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      case (i_addr)
        pms_pkg::CTL_WDATA: o_rdata <= wdata;
        pms_pkg::CTL_RDATA: o_rdata <= rdata;
        pms_pkg::CTL_STATUS: o_rdata <= {15'h0000, state == pms_pkg::C_RUN};
        pms_pkg::CTL_IRQ_STAT: o_rdata <= {14'h0000, irq_stat};
        pms_pkg::CTL_IRQ_MASK: o_rdata <= {14'h0000, irq_mask};
        default: o_rdata <= 16'h0000;
      endcase
    end else begin
      o_rdata <= 16'h0000;
    end
  end

  // Level interrupt while an unmasked flag stands
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_stat & irq_mask);
    end
  end
endmodule : pms_ctl

// >>> rtl/pms_if.sv
// Two-wire management link: controller-driven clock and one shared data line.
// Assumes a pull-up on the data line; each end gives value plus active-low enable.
`timescale 1ns/10ps
interface pms_if;
  logic mdc;           // Link clock, driven by the controller
  logic ctl_mdio_o;    // Controller data value
  logic ctl_mdio_oe_n; // Controller drives while low
  logic dev_mdio_o;    // Device data value
  logic dev_mdio_oe_n; // Device drives while low
  logic mdio;          // Resolved line level

  // Resolved level; released line floats high through the pull-up
  assign mdio = !ctl_mdio_oe_n ? ctl_mdio_o : (!dev_mdio_oe_n ? dev_mdio_o : 1'b1);

  modport dev (input mdc, input mdio, output dev_mdio_o, output dev_mdio_oe_n);
  modport ctl (output mdc, output ctl_mdio_o, output ctl_mdio_oe_n, input mdio);
endinterface : pms_if

// >>> rtl/pms_phy.sv
// Device end: management serial slave, thirteen-word register set, interrupt pin.
// Assumes the link clock stays low or still between frames and is far slower than i_clk.
//
// Strobed register access was left to the implementer.
`timescale 1ns/10ps
module pms_phy (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_station_addr_straps,
  input wire logic [7:0] i_irq_events,
  pms_if.dev link,
  output logic o_irq_out_pin,
  output logic [2:0] o_station_addr,
  output logic o_straps_oe_n,
  output logic [15:0] o_ctrl0
);
  // Synchronised pins and the link clock edge
  logic [4:0] pins_s;
  logic mdc_rise;
  logic mdio_s;
  logic [2:0] straps_s;
  // Strap capture
  logic [1:0] strap_wait;
  logic strap_done;
  // Receive machine
  pms_pkg::pms_dev_state_t state;
  logic [5:0] ones;          // Preamble ones seen, saturating
  logic [3:0] cnt;           // Bit counter within a field
  logic [11:0] hdr;          // Opcode, station and register address
  logic [15:0] shift;        // Read data out or write data in
  logic is_wr;               // Current frame is a write
  // Register set
  logic [15:0] regs [pms_pkg::IRQ_SLOT];
  logic [7:0] irq_en;
  logic [7:0] irq_stat;
  // Decode of the frame in flight
  logic [11:0] next_hdr;
  logic [1:0] hdr_op;
  logic [3:0] rd_slot;
  logic [3:0] wr_slot;
  logic hdr_match;
  logic hdr_end;
  logic do_read;
  logic do_write;
  logic [15:0] wr_word;
  logic [15:0] rd_word;
  logic irq_active;

  // Register address to storage slot, NO_SLOT when unmapped
  function automatic logic [3:0] slot_of(input logic [4:0] addr);
    logic [3:0] s;
    s = pms_pkg::NO_SLOT;
    for (int i = 0; i < pms_pkg::NUM_REGS; i++) begin
      if (pms_pkg::REG_MAP[i] == addr) begin
        s = 4'(i);
      end
    end
    return s;
  endfunction : slot_of

  // clock and data from link
  // Link pins and straps all arrive from outside this clock
  pms_sync #(.W(5)) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_d({i_station_addr_straps, link.mdio, link.mdc}),
    .o_q(pins_s),
    .o_rise(mdc_rise)
  );
  assign mdio_s = pins_s[1];
  assign straps_s = pins_s[4:2];

  // straps caught after release
  // Waits for the synchroniser to fill, then holds the address for good
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      strap_wait <= 2'h0;
      strap_done <= 1'b0;
      o_station_addr <= 3'h0;
      o_straps_oe_n <= 1'b1;
    end else if (!strap_done) begin
      strap_wait <= strap_wait + 2'h1;
      if (strap_wait == pms_pkg::STRAP_SETTLE) begin
        o_station_addr <= straps_s;
        strap_done <= 1'b1;
        // Pins turn into outputs once latched
        o_straps_oe_n <= 1'b0;
      end
    end
  end

  // Header decode on the bit that completes it
  always_comb begin
    next_hdr = {hdr[10:0], mdio_s};
    hdr_op = next_hdr[11:10];
    rd_slot = slot_of(next_hdr[4:0]);
    wr_slot = slot_of(hdr[4:0]);
    hdr_match = strap_done && (o_station_addr != 3'h0) && (next_hdr[9:5] == {2'h0, o_station_addr});
    hdr_end = mdc_rise && (state == pms_pkg::S_HDR) && (cnt == 4'(pms_pkg::HDR_BITS - 1));
    do_read = hdr_end && hdr_match && (hdr_op == pms_pkg::OP_RD);
    do_write = mdc_rise && (state == pms_pkg::S_DATA) && is_wr && (cnt == 4'(pms_pkg::DATA_BITS - 1));
    wr_word = {shift[14:0], mdio_s};
    if (rd_slot < 4'(pms_pkg::IRQ_SLOT)) begin
      rd_word = regs[rd_slot];
    end else if (rd_slot == 4'(pms_pkg::IRQ_SLOT)) begin
      rd_word = {irq_en, irq_stat};
    end else begin
      rd_word = 16'h0000;
    end
  end

  // frame machine steps on rising link edges only
  // no dependence on the data interface mode
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= pms_pkg::S_PRE;
      ones <= 6'h00;
      cnt <= 4'h0;
      hdr <= 12'h000;
      shift <= 16'h0000;
      is_wr <= 1'b0;
      link.dev_mdio_o <= 1'b1;
      link.dev_mdio_oe_n <= 1'b1;
    end else if (mdc_rise) begin
      case (state)
        // count at least 32 ones, then the start zero
        pms_pkg::S_PRE: begin
          if (mdio_s) begin
            if (ones != 6'(pms_pkg::PRE_LEN)) begin
              ones <= ones + 6'h01;
            end
          end else begin
            if (ones == 6'(pms_pkg::PRE_LEN)) begin
              state <= pms_pkg::S_ST;
            end
            ones <= 6'h00;
          end
        end
        // Second start bit must be one
        pms_pkg::S_ST: begin
          cnt <= 4'h0;
          state <= mdio_s ? pms_pkg::S_HDR : pms_pkg::S_PRE;
        end
        // Opcode and both addresses
        pms_pkg::S_HDR: begin
          hdr <= next_hdr;
          cnt <= cnt + 4'h1;
          if (hdr_end) begin
            cnt <= 4'h0;
            // foreign or bad frames drop back to hunting
            if (hdr_match && (hdr_op == pms_pkg::OP_RD || hdr_op == pms_pkg::OP_WR)) begin
              state <= pms_pkg::S_TA;
              is_wr <= (hdr_op == pms_pkg::OP_WR);
              shift <= rd_word;
            end else begin
              state <= pms_pkg::S_PRE;
            end
          end
        end
        // stay off for first turnaround bit, then drive zero on reads only
        pms_pkg::S_TA: begin
          cnt <= cnt + 4'h1;
          if (cnt == 4'h0 && !is_wr) begin
            link.dev_mdio_oe_n <= 1'b0;
            link.dev_mdio_o <= 1'b0;
          end
          if (cnt == 4'h1) begin
            cnt <= 4'h0;
            state <= pms_pkg::S_DATA;
            if (!is_wr) begin
              link.dev_mdio_o <= shift[15];
              shift <= {shift[14:0], 1'b0};
            end
          end
        end
        // sixteen bits, msb first, then release
        pms_pkg::S_DATA: begin
          cnt <= cnt + 4'h1;
          if (is_wr) begin
            shift <= wr_word;
          end else begin
            link.dev_mdio_o <= shift[15];
            shift <= {shift[14:0], 1'b0};
          end
          if (cnt == 4'(pms_pkg::DATA_BITS - 1)) begin
            cnt <= 4'h0;
            state <= pms_pkg::S_PRE;
            link.dev_mdio_oe_n <= 1'b1;
            link.dev_mdio_o <= 1'b1;
          end
        end
        // Unknown state recovers to hunting
        default: begin
          state <= pms_pkg::S_PRE;
        end
      endcase
    end
  end

  // general words written by write frames
  // Status bits of the interrupt word stay read-only
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < pms_pkg::IRQ_SLOT; i++) begin
        regs[i] <= pms_pkg::REG_RST;
      end
      irq_en <= pms_pkg::IRQ_EN_RST;
    end else if (do_write) begin
      if (wr_slot < 4'(pms_pkg::IRQ_SLOT)) begin
        regs[wr_slot] <= wr_word;
      end else if (wr_slot == 4'(pms_pkg::IRQ_SLOT)) begin
        irq_en <= wr_word[15:8];
      end
    end
  end

  // read clears after the value is captured; a new event wins
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_stat <= 8'h00;
    end else begin
      irq_stat <= ((do_read && rd_slot == 4'(pms_pkg::IRQ_SLOT)) ? 8'h00 : irq_stat) | i_irq_events;
    end
  end

  // only enabled conditions reach the pin
  assign irq_active = |(irq_en & irq_stat);

  // pin flags a pending enabled condition
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irq_out_pin <= pms_pkg::IRQ_PIN_RST;
    end else begin
      o_irq_out_pin <= regs[pms_pkg::CTRL2_SLOT][pms_pkg::IRQ_POL_BIT] ? irq_active : ~irq_active;
    end
  end

  // First control word steers the rest of the transceiver
  assign o_ctrl0 = regs[0];
endmodule : pms_phy

// >>> rtl/pms_pkg.sv
// Shared constants and types for the management serial link and its two ends.
// Assumes a single core clock of 125 MHz on both ends.
package pms_pkg;
  // Core clock period and the fastest legal link clock period
  localparam int CLK_PERIOD_NS = 8;
  localparam int MDC_MIN_PERIOD_NS = 160;
  // Half link period in core cycles, rounded up so the link is never too fast
  localparam int MDC_HALF_CYCLES = (MDC_MIN_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
  // Frame layout, bit positions counted from the first preamble bit
  localparam int PRE_LEN = 32;
  localparam int HDR_BITS = 12;
  localparam int DATA_BITS = 16;
  localparam int FRAME_BITS = 64;
  localparam int TA_FIRST_BIT = 46;
  localparam int DATA_FIRST_BIT = 48;
  localparam logic [1:0] START_PAT = 2'h1;
  localparam logic [1:0] OP_RD = 2'h2;
  localparam logic [1:0] OP_WR = 2'h1;
  localparam logic [1:0] TA_WR = 2'h2;
  // Device register set: thirteen words, slot order below
  localparam int NUM_REGS = 13;
  localparam int IRQ_SLOT = 12;
  localparam int CTRL2_SLOT = 11;
  localparam logic [3:0] NO_SLOT = 4'hF;
  localparam logic [4:0] REG_MAP [NUM_REGS] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06,
                                                 5'h14, 5'h15, 5'h18, 5'h1E, 5'h1F, 5'h1B};
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [7:0] IRQ_EN_RST = 8'h00;
  localparam int IRQ_POL_BIT = 9;
  localparam logic IRQ_PIN_RST = 1'b1;
  // Core cycles after reset release before the straps are trusted
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  // Controller register offsets and fields
  localparam logic [2:0] CTL_CMD = 3'h0;
  localparam logic [2:0] CTL_WDATA = 3'h1;
  localparam logic [2:0] CTL_RDATA = 3'h2;
  localparam logic [2:0] CTL_STATUS = 3'h3;
  localparam logic [2:0] CTL_IRQ_STAT = 3'h4;
  localparam logic [2:0] CTL_IRQ_MASK = 3'h5;
  localparam int CMD_READ_BIT = 10;
  localparam int CMD_PHY_LSB = 5;
  localparam int EV_WR_DONE = 0;
  localparam int EV_RD_DONE = 1;

  // Device receive states
  typedef enum logic [2:0] {S_PRE, S_ST, S_HDR, S_TA, S_DATA} pms_dev_state_t;
  // Controller states
  typedef enum logic [0:0] {C_IDLE, C_RUN} pms_ctl_state_t;
endpackage : pms_pkg

// >>> rtl/pms_sync.sv
// Two-stage synchroniser with a rising-edge detect on bit 0.
// Assumes inputs are asynchronous to i_clk.
`timescale 1ns/10ps
module pms_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q,
  output logic o_rise
);
  logic [W-1:0] meta; // First stage, read only by o_q
  logic prev;         // Delayed bit 0 for edge finding

  // Refuse an empty vector
  if (W < 1) begin : g_bad_w
    $error("pms_sync width must be at least one");
  end

  // Two flops, then one more for the edge
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta <= '0;
      o_q <= '0;
      prev <= 1'b0;
    end else begin
      meta <= i_d;
      o_q <= meta;
      prev <= o_q[0];
    end
  end

  // One-cycle pulse per rising edge of bit 0
  assign o_rise = o_q[0] & ~prev;
endmodule : pms_sync

// >>> tb/phy_mgmt_serial_irq_bench.sv
// Bench joining controller and device ends over one link interface.
// Assumes the controller register port is the only software path to the device.
`timescale 1ns/10ps
module phy_mgmt_serial_irq_bench;
  logic i_clk, i_rst, wr, rd, irq, irq_pin, st_oe_n;
  logic [2:0] addr, straps, st_addr;
  logic [15:0] wdata, rdata, ctrl0;
  logic [7:0] ev; // Device event pulses
  int n_errors, total_checks;

  pms_if i_pms_if();
  pms_ctl #(.HALF(4)) i_pms_ctl(.i_clk(i_clk), .i_rst(i_rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .o_irq(irq), .link(i_pms_if.ctl));
  pms_phy i_pms_phy(.i_clk(i_clk), .i_rst(i_rst), .i_station_addr_straps(straps), .i_irq_events(ev),
    .link(i_pms_if.dev), .o_irq_out_pin(irq_pin), .o_station_addr(st_addr), .o_straps_oe_n(st_oe_n), .o_ctrl0(ctrl0));
  pms_link_checker #(.HALF(4)) i_pms_link_checker(.i_clk(i_clk), .i_rst(i_rst), .mdc(i_pms_if.mdc),
    .ctl_mdio_o(i_pms_if.ctl_mdio_o), .ctl_mdio_oe_n(i_pms_if.ctl_mdio_oe_n), .dev_mdio_o(i_pms_if.dev_mdio_o),
    .dev_mdio_oe_n(i_pms_if.dev_mdio_oe_n), .mdio(i_pms_if.mdio), .i_station_addr(st_addr));

  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string w, input logic [15:0] e, input logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", w, e, s);
    end
  endtask : check

  // Flags are looked at mid-cycle, away from the edge that moves them
  task automatic chk_neg(input string w, input logic e, ref logic s);
    @(negedge i_clk);
    check(w, 16'(e), 16'(s));
    @(posedge i_clk);
  endtask : chk_neg

  // Expected pin level from polarity, enables and status
  function automatic logic exp_pin(input logic pol, input logic [7:0] en, input logic [7:0] st);
    return pol ? |(en & st) : ~|(en & st);
  endfunction : exp_pin

  task automatic reg_wr(input logic [2:0] a, input logic [15:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
    // Quiet cycle, so a following write never reassigns the strobe in one step
    @(posedge i_clk);
  endtask : reg_wr

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [2:0] a, output logic [15:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    #1 v = rdata;
    @(posedge i_clk);
  endtask : reg_rd

  // device reached only by frames
  // One management frame, waited out by polling the busy flag
  task automatic frame(input logic rd_op, input logic [2:0] phy, input logic [4:0] ra, input logic [15:0] v,
                       output logic [15:0] got);
    logic [15:0] s;
    s = 16'h0001;
    reg_wr(pms_pkg::CTL_WDATA, v);
    reg_wr(pms_pkg::CTL_CMD, {5'h00, rd_op, 2'h0, phy, ra});
    for (int k = 0; k < 400 && s[0] !== 1'b0; k++) begin
      reg_rd(pms_pkg::CTL_STATUS, s);
    end
    check("busy", 16'h0000, {15'h0000, s[0]});
    reg_rd(pms_pkg::CTL_RDATA, got);
  endtask : frame

  // Single cycle event burst, then time for the pin to follow
  task automatic pulse(input logic [7:0] v);
    ev <= v;
    @(posedge i_clk);
    ev <= 8'h00;
    repeat (3) @(posedge i_clk);
  endtask : pulse

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // Watchdog, well beyond the thirty-four frames
  initial begin
    #400000;
    n_errors++;
    end_of_test();
  end

  initial begin
    logic [15:0] got, v;
    logic [7:0] r;
    void'($urandom(32'hD22ED68F));
    i_rst = 1'b1;
    addr = 3'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    ev = 8'h00;
    straps = 3'($urandom_range(7, 1));
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
    check("station addr", 16'(straps), 16'(st_addr));
    check("straps oe_n", 16'h0000, 16'(st_oe_n));
    // Every register except the interrupt word written with random data and read back
    for (int i = 0; i < pms_pkg::NUM_REGS; i++) begin
      if (i != pms_pkg::IRQ_SLOT) begin
        v = 16'($urandom);
        frame(1'b0, straps, pms_pkg::REG_MAP[i], v, got);
        frame(1'b1, straps, pms_pkg::REG_MAP[i], 16'h0000, got);
        check("reg readback", v, got);
      end
    end
    // Controller interrupt, masked then unmasked, and an unmapped read
    reg_rd(pms_pkg::CTL_IRQ_STAT, got);
    check("ctl irq stat all", 16'h0003, got);
    reg_wr(pms_pkg::CTL_IRQ_MASK, 16'h0002);
    frame(1'b0, straps, 5'h00, 16'h1234, got);
    chk_neg("ctl irq masked", 1'b0, irq);
    check("ctrl0", 16'h1234, ctrl0);
    reg_rd(pms_pkg::CTL_WDATA, got);
    check("wdata", 16'h1234, got);
    frame(1'b1, straps, 5'h00, 16'h0000, got);
    chk_neg("ctl irq", 1'b1, irq);
    reg_rd(pms_pkg::CTL_IRQ_STAT, got);
    check("ctl irq stat", 16'h0003, got);
    chk_neg("ctl irq cleared", 1'b0, irq);
    reg_rd(pms_pkg::CTL_IRQ_MASK, got);
    check("irq mask", 16'h0002, got);
    reg_rd(3'h7, got);
    check("unmapped", 16'h0000, got);
    // Foreign and zero station addresses: line stays released
    frame(1'b0, straps % 3'h7 + 3'h1, 5'h00, 16'hBEEF, got);
    check("foreign write", 16'h1234, ctrl0);
    frame(1'b1, straps % 3'h7 + 3'h1, 5'h00, 16'h0000, got);
    check("foreign read", 16'hFFFF, got);
    frame(1'b1, 3'h0, 5'h00, 16'h0000, got);
    check("zero addr read", 16'hFFFF, got);
    // Device interrupt: enables, sticky status, clear on read, polarity
    frame(1'b0, straps, 5'h1F, 16'h0000, got);
    frame(1'b0, straps, 5'h1B, 16'h0500, got);
    chk_neg("pin idle low active", 1'b1, irq_pin);
    r = 8'($urandom) & 8'hFA;
    pulse(r);
    chk_neg("pin disabled events", exp_pin(1'b0, 8'h05, r), irq_pin);
    pulse(8'h04);
    chk_neg("pin asserted", exp_pin(1'b0, 8'h05, r | 8'h04), irq_pin);
    frame(1'b1, straps, 5'h1B, 16'h0000, got);
    check("irq reg", {8'h05, r | 8'h04}, got);
    chk_neg("pin after clear", 1'b1, irq_pin);
    frame(1'b1, straps, 5'h1B, 16'h0000, got);
    check("irq reg cleared", 16'h0500, got);
    frame(1'b0, straps, 5'h1F, 16'h0200, got);
    chk_neg("pin idle high active", 1'b0, irq_pin);
    pulse(8'h01);
    chk_neg("pin high active", exp_pin(1'b1, 8'h05, 8'h01), irq_pin);
    end_of_test();
  end
endmodule : phy_mgmt_serial_irq_bench

// >>> tb/pms_link_checker.sv
// Checker for the management serial link between the controller and device ends.
// Assumes one clock domain for both ends and the link clock held low between frames.
`timescale 1ns/10ps
module pms_link_checker #(
  parameter int HALF = 10
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic mdc,
  input wire logic ctl_mdio_o,
  input wire logic ctl_mdio_oe_n,
  input wire logic dev_mdio_o,
  input wire logic dev_mdio_oe_n,
  input wire logic mdio,
  input wire logic [2:0] i_station_addr
);
  // Longest wait for the line to go quiet after the last bit
  localparam int IDLE_MAX = 2 * HALF + 8;
  logic mdc_q; // Link clock one cycle late
  logic rise; // Link clock rising edge seen
  logic [6:0] cnt; // Index of the bit under the next rise
  logic [3:0] sh; // Last sampled bits
  logic op_rd; // Current frame is a read
  logic hit; // Current frame addresses this device

  assign rise = mdc && !mdc_q;

  // Edge finder on the sampled link clock
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mdc_q <= 1'b0;
    end else begin
      mdc_q <= mdc;
    end
  end

  // Bit counter, restarted when the controller takes the line
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt <= 7'h00;
    end else if ($fell(ctl_mdio_oe_n)) begin
      cnt <= 7'h00;
    end else if (rise && cnt < 7'h40) begin
      cnt <= cnt + 7'h01;
    end
  end

  // Header capture: opcode and station field
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sh <= 4'h0;
      op_rd <= 1'b0;
      hit <= 1'b0;
    end else if (rise) begin
      sh <= {sh[2:0], mdio};
      if (cnt == 7'h23) begin
        op_rd <= {sh[0], mdio} == 2'h2;
      end
      if (cnt == 7'h28) begin
        hit <= ({sh, mdio} == {2'h0, i_station_addr}) && (i_station_addr != 3'h0);
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_one_driver: assert property (ctl_mdio_oe_n || dev_mdio_oe_n) else $error("both ends drive the line");
  a_pre_ones: assert property (rise && cnt < 7'h20 && !ctl_mdio_oe_n |-> mdio) else $error("preamble bit low");
  a_start_bits: assert property (rise && (cnt == 7'h20 || cnt == 7'h21) |-> mdio == (cnt == 7'h21))
    else $error("start pattern wrong");
  a_op_valid: assert property (rise && cnt == 7'h23 |-> mdio != sh[0]) else $error("opcode not read or write");
  a_phy_top_zero: assert property (rise && (cnt == 7'h24 || cnt == 7'h25) |-> !mdio)
    else $error("station field top bits set");
  a_ta_release: assert property (rise && cnt == 7'h2E && op_rd |-> ctl_mdio_oe_n && dev_mdio_oe_n)
    else $error("read turnaround not released");
  a_ta_write: assert property (rise && cnt == 7'h2E && !op_rd |-> mdio) else $error("write turnaround not one");
  a_ta_zero: assert property (rise && cnt == 7'h2F && (hit || !op_rd) |-> !mdio) else $error("turnaround not zero");
  a_read_answer: assert property (rise && cnt == 7'h30 && op_rd && hit |-> !dev_mdio_oe_n)
    else $error("device silent on own read");
  a_foreign_quiet: assert property (cnt > 7'h28 && !hit |-> dev_mdio_oe_n) else $error("device drives foreign frame");
  a_write_quiet: assert property (cnt > 7'h23 && !op_rd |-> dev_mdio_oe_n) else $error("device drives in write");
  a_drive_window: assert property (!dev_mdio_oe_n |-> cnt > 7'h2E) else $error("device drives before turnaround");
  a_idle_release: assert property ($rose(cnt == 7'h40) |-> ##[1:IDLE_MAX] (ctl_mdio_oe_n && dev_mdio_oe_n && !mdc))
    else $error("line not idle after frame");
endmodule : pms_link_checker
